// *** adc_conversion_sequencer.sv ***
// Contract
// [R1] conversion takes exactly eleven bit periods
// [R2] clock select picks divider or rc
// [R3] software retunes fields for power modes
// [R4] software keeps clock source during conversion
// [R5] below 1 MHz software picks rc
// [R6] sleep conversion needs rc clock selected
// [R7] zero acquisition delays one instruction cycle
// [R8] software clears idle bit before sleep
// [R9] analog pins read zero on port
// [R10] selected pin converted regardless of direction
// [R11] zero acquisition converts after next instruction
// [R12] code 010 samples four periods first
// [R13] clearing busy bit aborts conversion immediately
// [R14] abort leaves result pair unchanged
// [R15] two period wait after end or abort
// [R16] after wait resume sampling selected channel
// [R17] software never starts in enabling write
// [R18] software sets capture mode 1011, enables
// [R19] trigger sets busy, starts, clears timer
// [R20] disabled converter ignores trigger, timer cleared
// [R21] completion loads result, clears busy, flags
// [R22] acquisition field decodes to period counts
// [R23] reset turns off and aborts
// [R24] justify bit right when set, left clear
// [R25] start while disabled is ignored
`timescale 1ns/1ps
`default_nettype none
module adc_conversion_sequencer
  import adc_seq_pkg::*;
(
  input  wire logic                ref_clk,
  input  wire logic                nrst,
  input  wire logic                converter_on,
  input  wire logic                go_set,
  input  wire logic                go_clear,
  input  wire logic [2:0]          conv_clock_select,
  input  wire logic [2:0]          acq_time_select,
  input  wire logic                result_justify,
  input  wire logic [3:0]          channel_select,
  input  wire logic [3:0]          capture_mode_field,
  input  wire logic                special_event,
  input  wire logic                result_write,
  input  wire logic [7:0]          result_high_wdata,
  input  wire logic [7:0]          result_low_wdata,
  input  wire logic                flag_clear,
  input  wire logic [CHANNELS-1:0] pin_level,
  input  wire logic [CHANNELS-1:0] analog_select,
  input  wire logic                comp_out,
  output logic                     go_busy,
  output logic                     conversion_done_flag,
  output logic [7:0]               result_high_byte,
  output logic [7:0]               result_low_byte,
  output logic                     sampling,
  output logic                     hold,
  output logic [3:0]               sample_channel,
  output logic [RESULT_WIDTH-1:0]  dac_trial,
  output logic                     timer_reset,
  output logic [CHANNELS-1:0]      port_read
);
  seq_state_t state_q;
  seq_state_t state_d;
  logic [4:0]  tad_cnt_q;
  logic [7:0]  instr_cnt_q;
  logic [1:0]  pin_s1_q;
  logic [1:0]  pin_s2_q;
  logic [CHANNELS-1:0] pins_s1_q;
  logic [CHANNELS-1:0] pins_s2_q;
  logic [RESULT_WIDTH-1:0] result_q;
  logic [RESULT_WIDTH-1:0] trial;
  logic [RESULT_WIDTH-1:0] sar_value;
  logic [4:0]  acq_tads;
  logic        tad_tick;
  logic        trig_fire;
  logic        start_req;
  logic        abort;
  logic        conv_done;
  logic        sar_start;
  logic        sar_step;
  logic        run_clk;
  logic        comp_sync;
  logic [7:0]  res_hi;
  logic [7:0]  res_lo;

  assign acq_tads = (acq_time_select == 3'h7) ? 5'd20 :
                    (acq_time_select == 3'h6) ? 5'd16 :
                    (acq_time_select == 3'h5) ? 5'd12 :
                    (acq_time_select == 3'h4) ? 5'd8  :
                    (acq_time_select == 3'h3) ? 5'd6  :
                    (acq_time_select == 3'h2) ? 5'd4  :
                    (acq_time_select == 3'h1) ? 5'd2  : 5'd0; // [R22] [R12]
  assign trig_fire = special_event && capture_mode_field == TRIGGER_MODE;
  // start only from idle sampling, so a disabled converter never starts
  assign start_req = (go_set || trig_fire) && converter_on && state_q == ST_SAMP; // [R25] [R20] [R19]
  assign abort     = (go_clear || !converter_on) && (state_q == ST_ACQ || state_q == ST_CONV); // [R13]
  assign conv_done = state_q == ST_CONV && tad_tick && tad_cnt_q == 5'(CONV_TAD_COUNT - 1); // [R1]
  // the divider restarts on every phase change, so each phase gets whole bit periods
  assign run_clk   = state_q != ST_OFF && state_q != ST_SAMP && state_d == state_q; // [R1] [R15]
  assign sar_start = state_d == ST_CONV && state_q != ST_CONV;
  // first tad of the conversion settles, the ten after it decide one bit each
  assign sar_step  = state_q == ST_CONV && tad_tick && tad_cnt_q != 5'd0;
  assign comp_sync = pin_s2_q[1];
  assign res_hi = result_justify ? {6'h00, result_q[9:8]} : result_q[9:2]; // [R24]
  assign res_lo = result_justify ? result_q[7:0] : {result_q[1:0], 6'h00}; // [R24]

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_OFF:  if (converter_on) state_d = ST_SAMP;
      ST_SAMP: if (!converter_on) state_d = ST_OFF;
               else if (start_req) state_d = ST_ACQ;
      ST_ACQ:  if (abort) state_d = ST_WAIT; // [R13]
               else if (acq_tads == 5'd0 && instr_cnt_q >= INSTR_CYCLE_CLKS) state_d = ST_CONV; // [R7] [R11]
               else if (acq_tads != 5'd0 && tad_tick && tad_cnt_q == acq_tads - 5'd1) state_d = ST_CONV; // [R12]
      ST_CONV: if (abort || conv_done) state_d = ST_WAIT; // [R15]
      ST_WAIT: if (tad_tick && tad_cnt_q == 5'(POST_WAIT_TAD - 1)) state_d = converter_on ? ST_SAMP : ST_OFF; // [R15] [R16]
      default: state_d = ST_OFF;
    endcase
  end

  adc_tad_gen u_tad (
    .ref_clk           (ref_clk),
    .nrst              (nrst),
    .run               (run_clk),
    .conv_clock_select (conv_clock_select),
    .tad_tick          (tad_tick)
  );

  adc_sar_core u_sar (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .start   (sar_start),
    .step    (sar_step),
    .comp_in (comp_sync),
    .trial   (trial),
    .value   (sar_value)
  );

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= ST_OFF; // [R23]
      tad_cnt_q <= 5'd0;
      instr_cnt_q <= 8'h00;
    end else begin
      state_q <= state_d;
      tad_cnt_q <= (state_d != state_q) ? 5'd0 : (tad_tick ? tad_cnt_q + 5'd1 : tad_cnt_q);
      instr_cnt_q <= (state_q == ST_ACQ) ? instr_cnt_q + 8'h01 : 8'h00;
    end
  end

  // comparator output and pins come from the analog side, synchronised first
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pin_s1_q  <= 2'h0;
      pin_s2_q  <= 2'h0;
      pins_s1_q <= '0;
      pins_s2_q <= '0;
    end else begin
      pin_s1_q  <= {comp_out, 1'b0};
      pin_s2_q  <= pin_s1_q;
      pins_s1_q <= pin_level;
      pins_s2_q <= pins_s1_q;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      result_q <= RESULT_RESET;
      go_busy  <= 1'b0; // [R23]
      conversion_done_flag <= 1'b0;
    end else begin
      if (conv_done) result_q <= {sar_value[9:1], sar_value[0] | (comp_sync & ~|sar_value[0])}; // [R21]
      else if (result_write) result_q <= result_justify ? {result_high_wdata[1:0], result_low_wdata}
                                                      : {result_high_wdata, result_low_wdata[7:6]}; // [R14]
      if (start_req) go_busy <= 1'b1; // [R19]
      else if (conv_done || abort || state_q == ST_OFF) go_busy <= 1'b0; // [R21] [R13]
      if (conv_done) conversion_done_flag <= 1'b1; // [R21]
      else if (flag_clear) conversion_done_flag <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      result_high_byte <= 8'h00;
      result_low_byte  <= 8'h00;
      sampling         <= 1'b0;
      hold             <= 1'b0;
      sample_channel   <= 4'h0;
      dac_trial        <= '0;
      timer_reset      <= 1'b0;
      port_read        <= '0;
    end else begin
      result_high_byte <= res_hi;
      result_low_byte  <= res_lo;
      sampling         <= state_d == ST_SAMP || state_d == ST_ACQ; // [R16]
      hold             <= state_d == ST_CONV;
      // channel goes out untouched by direction bits; the pad mux converts whatever drives it
      sample_channel   <= channel_select; // [R10]
      dac_trial        <= trial;
      timer_reset      <= trig_fire; // [R19] [R20]
      port_read        <= pins_s2_q & ~analog_select; // [R9]
    end
  end
endmodule
`default_nettype wire

// *** adc_seq_pkg.sv ***
package adc_seq_pkg;
  localparam int          CONV_TAD_COUNT   = 11;
  localparam int          POST_WAIT_TAD    = 2;
  localparam logic [3:0]  TRIGGER_MODE     = 4'hB;
  localparam logic [7:0]  RC_HALF_PERIOD   = 8'h64;
  localparam logic [7:0]  INSTR_CYCLE_CLKS = 8'h04;
  localparam logic [2:0]  ACQT_NONE        = 3'h0;
  localparam logic [2:0]  CS_RESET         = 3'h0;
  localparam logic [2:0]  ACQT_RESET       = 3'h0;
  localparam logic [9:0]  RESULT_RESET     = 10'h000;
  localparam int          RESULT_WIDTH     = 10;
  localparam int          CHANNELS         = 16;
  typedef enum logic [4:0] {
    ST_OFF  = 5'h01,
    ST_SAMP = 5'h02,
    ST_ACQ  = 5'h04,
    ST_CONV = 5'h08,
    ST_WAIT = 5'h10
  } seq_state_t;
endpackage

// *** adc_tad_gen.sv ***
`timescale 1ns/1ps
`default_nettype none
module adc_tad_gen
  import adc_seq_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       nrst,
  input  wire logic       run,
  input  wire logic [2:0] conv_clock_select,
  output logic            tad_tick
);
  logic [7:0] cnt_q;
  logic [7:0] limit;
  // x11 picks the free internal rc source, modelled as a slow fixed divider
  // a period of n clocks counts 0 to n-1, so the limit is the divide ratio less one
  assign limit = (conv_clock_select[1:0] == 2'h3) ? (RC_HALF_PERIOD << 1) + 8'h01 :
                 (8'h02 << {conv_clock_select[1:0], conv_clock_select[2]}) - 8'h01; // [R2]
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_q    <= 8'h00;
      tad_tick <= 1'b0;
    end else if (!run || cnt_q >= limit) begin
      cnt_q    <= 8'h00;
      tad_tick <= run;
    end else begin
      cnt_q    <= cnt_q + 8'h01;
      tad_tick <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// *** adc_sar_core.sv ***
`timescale 1ns/1ps
`default_nettype none
module adc_sar_core
  import adc_seq_pkg::*;
(
  input  wire logic                    ref_clk,
  input  wire logic                    nrst,
  input  wire logic                    start,
  input  wire logic                    step,
  input  wire logic                    comp_in,
  output logic [RESULT_WIDTH-1:0]      trial,
  output logic [RESULT_WIDTH-1:0]      value
);
  logic [RESULT_WIDTH-1:0] mask_q;
  logic [RESULT_WIDTH-1:0] acc_q;
  assign trial = acc_q | mask_q;
  assign value = acc_q;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      mask_q <= '0;
      acc_q  <= '0;
    end else if (start) begin
      mask_q <= {1'b1, {(RESULT_WIDTH-1){1'b0}}};
      acc_q  <= '0;
    end else if (step && mask_q != '0) begin
      if (comp_in) acc_q <= acc_q | mask_q;
      mask_q <= mask_q >> 1;
    end
  end
endmodule
`default_nettype wire

// *** adc_seq_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
module adc_seq_checker
  import adc_seq_pkg::*;
(
  input wire logic                ref_clk,
  input wire logic                nrst,
  input wire logic                converter_on,
  input wire logic                go_set,
  input wire logic                go_clear,
  input wire logic [3:0]          capture_mode_field,
  input wire logic                special_event,
  input wire logic [CHANNELS-1:0] analog_select,
  input wire logic                go_busy,
  input wire logic                conversion_done_flag,
  input wire logic [7:0]          result_high_byte,
  input wire logic [7:0]          result_low_byte,
  input wire logic                sampling,
  input wire logic                timer_reset,
  input wire logic [CHANNELS-1:0] port_read
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  wire logic trig = special_event && (capture_mode_field == TRIGGER_MODE);
  go_start_a: assert property (go_set && converter_on && sampling && !go_busy |=> go_busy)
    else $error("start not taken");
  trig_timer_a: assert property (trig |=> timer_reset)
    else $error("no timer reset");
  off_ignore_a: assert property ((go_set || trig) && !converter_on && !go_busy |=> !go_busy)
    else $error("start while off");
  abort_drop_a: assert property (go_busy && go_clear |=> !go_busy)
    else $error("abort ignored");
  abort_keep_a: assert property (go_busy && go_clear |=> ($stable(result_high_byte) && $stable(result_low_byte)) [*2])
    else $error("result changed on abort");
  done_flag_a: assert property ($fell(go_busy) && !$past(go_clear) && $past(converter_on) |-> conversion_done_flag)
    else $error("done flag missing");
  post_wait_a: assert property ($fell(go_busy) |-> !go_busy [*4])
    else $error("restart inside wait");
  port_zero_a: assert property ($stable(analog_select) |-> (port_read & analog_select) == '0)
    else $error("analog pin reads high");
  cover property ($fell(go_busy) && conversion_done_flag);
  cover property (trig && converter_on);
  cover property (go_busy && go_clear);
endmodule
bind adc_conversion_sequencer adc_seq_checker chk (.ref_clk, .nrst, .converter_on, .go_set, .go_clear, .capture_mode_field,
  .special_event, .analog_select, .go_busy, .conversion_done_flag, .result_high_byte, .result_low_byte, .sampling, .timer_reset, .port_read);
`default_nettype wire

// *** adc_conversion_sequencer_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module adc_conversion_sequencer_tb_top;
  import adc_seq_pkg::*;
  logic                ref_clk, nrst, converter_on, go_set, go_clear, result_justify, special_event, result_write;
  logic                flag_clear, comp_out, go_busy, conversion_done_flag, sampling, timer_reset;
  logic [2:0]          conv_clock_select, acq_time_select;
  logic [3:0]          channel_select, capture_mode_field, sample_channel;
  logic [7:0]          result_high_wdata, result_low_wdata, result_high_byte, result_low_byte;
  logic [CHANNELS-1:0] pin_level, analog_select, port_read;
  int                  mismatches, samples_checked, cycles, n;
  // last code is the rc source, the one a slow clock or sleep would use
  logic [2:0]          codes [7] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6, 3'h3};
  int                  divs [7] = '{2, 4, 8, 16, 32, 64, 202};
  adc_conversion_sequencer dut (.ref_clk, .nrst, .converter_on, .go_set, .go_clear, .conv_clock_select, .acq_time_select,
    .result_justify, .channel_select, .capture_mode_field, .special_event, .result_write, .result_high_wdata,
    .result_low_wdata, .flag_clear, .pin_level, .analog_select, .comp_out, .go_busy, .conversion_done_flag,
    .result_high_byte, .result_low_byte, .sampling, .hold(), .sample_channel, .dac_trial(), .timer_reset, .port_read);
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic pulse(ref logic s);
    @(negedge ref_clk);
    s = 1'b1;
    @(negedge ref_clk);
    s = 1'b0;
  endtask
  // comp_out held constant, so a keep-every-bit search gives all ones or all zeros
  task automatic run_conv(input bit trig, input int abort_at, output int cnt);
    if (trig) pulse(special_event);
    else pulse(go_set);
    chk(go_busy, 1'b1);
    if (trig) chk(timer_reset, 1'b1);
    if (abort_at > 0) begin
      repeat (abort_at) @(negedge ref_clk);
      pulse(go_clear);
      chk(go_busy, 1'b0);
    end
    for (cnt = 0; cnt < 3000 && go_busy === 1'b1; cnt++) @(negedge ref_clk);
    for (int k = 0; k < 1000 && sampling !== 1'b1; k++) @(negedge ref_clk);
    @(negedge ref_clk);
  endtask
  task automatic end_of_test();
    if (mismatches == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      end_of_test();
    end
  end
  initial begin
    {nrst, converter_on, go_set, go_clear, special_event, result_write, flag_clear} = 7'h00;
    {conv_clock_select, acq_time_select, result_justify, comp_out, channel_select} = 12'h035;
    {capture_mode_field, result_high_wdata, result_low_wdata} = {TRIGGER_MODE, 16'hA55A};
    {pin_level, analog_select} = 32'hFFFF_00FF;
    repeat (6) @(negedge ref_clk);
    nrst = 1'b1;
    chk({go_busy, result_high_byte, result_low_byte}, 24'h0);
    pulse(go_set);
    pulse(special_event);
    chk({go_busy, timer_reset}, 24'h1);
    chk(port_read, 24'hFF00);
    converter_on = 1'b1;
    for (int i = 0; i < 7; i++) begin
      conv_clock_select = codes[i];
      run_conv(1'b0, 0, n);
      chk(n >= 11 * divs[i] + 4 && n <= 12 * divs[i] + 8, 1'b1);
      chk({conversion_done_flag, result_high_byte, result_low_byte}, 24'h103FF);
      pulse(flag_clear);
    end
    {conv_clock_select, acq_time_select, result_justify} = 7'h04;
    run_conv(1'b0, 0, n);
    chk(n >= 30 && n <= 40, 1'b1);
    chk({sampling, sample_channel, result_high_byte, result_low_byte}, 24'h15FFC0);
    comp_out = 1'b0;
    pulse(flag_clear);
    run_conv(1'b0, 12, n);
    chk({conversion_done_flag, result_high_byte, result_low_byte}, 24'h0FFC0);
    pulse(result_write);
    @(negedge ref_clk);
    chk({result_high_byte, result_low_byte}, 24'hA540);
    {acq_time_select, result_justify} = 4'hF;
    run_conv(1'b1, 0, n);
    chk({n >= 62 && n <= 72, conversion_done_flag, result_high_byte, result_low_byte}, 24'h30000);
    end_of_test();
  end
endmodule
`default_nettype wire
